// *** common/ubst_consts.svh ***
`ifndef UBST_CONSTS_SVH
`define UBST_CONSTS_SVH
// register byte offsets on the apb slave
`define UBST_OFF_ADDR_A 12'h000
`define UBST_OFF_AMASK_A 12'h004
`define UBST_OFF_CYC_A 12'h008
`define UBST_OFF_ADDR_B 12'h00c
`define UBST_OFF_AMASK_B 12'h010
`define UBST_OFF_DATA_B 12'h014
`define UBST_OFF_DMASK_B 12'h018
`define UBST_OFF_CYC_B 12'h01c
`define UBST_OFF_CTRL 12'h020
`define UBST_OFF_EXEC 12'h024
`define UBST_OFF_SRC 12'h028
`define UBST_OFF_DST 12'h02c
// control register fields
`define UBST_CTL_MFLA 15
`define UBST_CTL_MFLB 14
`define UBST_CTL_MFIA 13
`define UBST_CTL_MFIB 12
`define UBST_CTL_TRACE_EN 11
`define UBST_CTL_TIMING_A 10
`define UBST_CTL_DATA_EN 7
`define UBST_CTL_TIMING_B 6
`define UBST_CTL_CHAIN 3
`define UBST_CTL_COUNT_EN 0
`define UBST_CTL_WMASK 32'h0000fcc9
// bus cycle register fields
`define UBST_BC_MASK 16'h00ff
`define UBST_BC_BUS_HI 7
`define UBST_BC_BUS_LO 6
`define UBST_BC_ID_HI 5
`define UBST_BC_ID_LO 4
`define UBST_BC_RW_HI 3
`define UBST_BC_RW_LO 2
`define UBST_BC_SZ_HI 1
`define UBST_BC_SZ_LO 0
`define UBST_SZ_NONE 2'h0
`define UBST_SZ_BYTE 2'h1
`define UBST_SZ_WORD 2'h2
`define UBST_SZ_LONG 2'h3
`define UBST_SEL_OFF 2'h0
`define UBST_BUS_IBUS 2'h2
`define UBST_KIND_FETCH 2'h1
`define UBST_KIND_DATA 2'h2
`define UBST_DIR_READ 2'h1
`define UBST_DIR_WRITE 2'h2
// execution count and trace fields
`define UBST_EXEC_MASK 16'h0fff
`define UBST_EXEC_ONE 12'h001
`define UBST_VALID_BIT 31
`define UBST_ADDR_W 28
`define UBST_DEPTH 4
`endif

// *** common/ubst_pkg.sv ***
// Purpose: types for the user break sequence and trace block
// Assumes: widths written out here match the consts header
// Notes: state record held in one struct
package ubst_pkg;
    typedef enum logic [1:0] {
        UBST_SEQ_IDLE = 2'b01,
        UBST_SEQ_ARMED = 2'b10
    } ubst_seq_t;

    typedef struct packed {
        logic [31:0] bar_a;
        logic [31:0] bam_a;
        logic [15:0] bbr_a;
        logic [31:0] bar_b;
        logic [31:0] bam_b;
        logic [31:0] bdr_b;
        logic [31:0] bdm_b;
        logic [15:0] bbr_b;
        logic [31:0] ctrl;
        logic [11:0] exec_cnt;
        ubst_seq_t seq;
        logic [3:0][27:0] src;
        logic [3:0][27:0] dst;
        logic [3:0] src_v;
        logic [3:0] dst_v;
        logic [31:0] rdata;
        logic brk;
        logic ap_ib;
        logic bp_ib;
    } ubst_state_t;
endpackage : ubst_pkg

// *** core/ubst_core.sv ***
// Purpose: user break match, sequential/count break, branch trace queue
// Assumes: cpu bus inputs are on i_clock; apb slave with zero wait states
// Notes: one registered break request pulse per cycle in which a channel fires
`include "ubst_consts.svh"

module ubst_core
    import ubst_pkg::*;
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // cpu bus cycle
    input wire logic i_cyc_valid,
    input wire logic i_cyc_ibus,
    input wire logic i_cyc_data,
    input wire logic i_cyc_write,
    input wire logic [1:0] i_cyc_size,
    input wire logic [31:0] i_cyc_addr,
    input wire logic [31:0] i_cyc_wdata,
    input wire logic i_fetch_exec,
    input wire logic i_brk_accept,
    // branch trace
    input wire logic i_branch,
    input wire logic [31:0] i_branch_src,
    input wire logic [31:0] i_branch_dst,
    // break request
    output logic o_break_req
);
    ubst_state_t s_q;
    ubst_state_t s_d;

    // channel condition: bus, kind, direction, size, address, data
    function automatic logic chan_hit(
        input logic [15:0] bbr,
        input logic [31:0] bar,
        input logic [31:0] bam,
        input logic data_en,
        input logic [31:0] bdr,
        input logic [31:0] bdm
    );
        logic [1:0] bus;
        logic [1:0] kind;
        logic [1:0] dir;
        logic [1:0] sz;
        logic [31:0] amask;
        logic [31:0] dmask;
        logic ok;
        bus = bbr[`UBST_BC_BUS_HI:`UBST_BC_BUS_LO];
        kind = bbr[`UBST_BC_ID_HI:`UBST_BC_ID_LO];
        dir = bbr[`UBST_BC_RW_HI:`UBST_BC_RW_LO];
        sz = bbr[`UBST_BC_SZ_HI:`UBST_BC_SZ_LO];
        amask = ~bam;
        dmask = ~bdm;
        ok = i_cyc_valid;
        if (bus == `UBST_SEL_OFF || kind == `UBST_SEL_OFF ||
            dir == `UBST_SEL_OFF) begin
            ok = 1'b0;
        end
        if (bus == `UBST_BUS_IBUS && !i_cyc_ibus) begin
            ok = 1'b0;
        end
        // bus code 11 means the l bus, like 01
        if (bus != `UBST_BUS_IBUS && i_cyc_ibus) begin
            ok = 1'b0;
        end
        if (kind == `UBST_KIND_FETCH && i_cyc_data) begin
            ok = 1'b0;
        end
        if (kind == `UBST_KIND_DATA && !i_cyc_data) begin
            ok = 1'b0;
        end
        if ((dir == `UBST_DIR_READ && i_cyc_write) ||
            (dir == `UBST_DIR_WRITE && !i_cyc_write)) begin
            ok = 1'b0;
        end
        if (sz != `UBST_SZ_NONE && sz != i_cyc_size) begin
            ok = 1'b0;
        end
        // fetches are halfword aligned, so a set lsb can never match
        if (i_cyc_data) begin
            unique case (i_cyc_size)
                `UBST_SZ_LONG: amask[1:0] = 2'h0;
                `UBST_SZ_WORD: amask[0] = 1'b0;
                default: amask = amask;
            endcase
        end else if (bar[0]) begin
            ok = 1'b0;
        end
        if (((bar ^ i_cyc_addr) & amask) != 32'h0) begin
            ok = 1'b0;
        end
        if (data_en && i_cyc_data) begin
            if (sz != `UBST_SZ_LONG) begin
                dmask[31:16] = 16'h0;
            end
            if (sz == `UBST_SZ_NONE ||
                ((bdr ^ i_cyc_wdata) & dmask) != 32'h0) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction : chan_hit

    logic apb_wr;
    logic apb_rd;
    logic hit_a;
    logic hit_b;
    logic [31:0] rd_mux;
    logic apb_rsetup;

    // read data is taken in the setup cycle, so it stands at the access edge
    assign apb_rsetup = i_psel && !i_penable && !i_pwrite;
    assign apb_wr = i_psel && i_penable && i_pwrite;
    assign apb_rd = i_psel && i_penable && !i_pwrite;
    assign o_pready = 1'b1;
    assign o_prdata = s_q.rdata;

    always_comb begin
        // channel a has no data compare
        hit_a = chan_hit(s_q.bbr_a, s_q.bar_a, s_q.bam_a, 1'b0,
            32'h0, 32'h0);
        hit_b = chan_hit(s_q.bbr_b, s_q.bar_b, s_q.bam_b,
            s_q.ctrl[`UBST_CTL_DATA_EN], s_q.bdr_b, s_q.bdm_b);
    end

    // unmapped addresses answer with an error and zero data
    always_comb begin
        o_pslverr = 1'b0;
        unique case (i_paddr)
            `UBST_OFF_ADDR_A: rd_mux = s_q.bar_a;
            `UBST_OFF_AMASK_A: rd_mux = s_q.bam_a;
            `UBST_OFF_CYC_A: rd_mux = {16'h0, s_q.bbr_a};
            `UBST_OFF_ADDR_B: rd_mux = s_q.bar_b;
            `UBST_OFF_AMASK_B: rd_mux = s_q.bam_b;
            `UBST_OFF_DATA_B: rd_mux = s_q.bdr_b;
            `UBST_OFF_DMASK_B: rd_mux = s_q.bdm_b;
            `UBST_OFF_CYC_B: rd_mux = {16'h0, s_q.bbr_b};
            `UBST_OFF_CTRL: rd_mux = s_q.ctrl;
            `UBST_OFF_EXEC: rd_mux = {20'h0, s_q.exec_cnt};
            `UBST_OFF_SRC: rd_mux = {s_q.src_v[0], 3'h0, s_q.src[0]};
            `UBST_OFF_DST: rd_mux = {s_q.dst_v[0], 3'h0, s_q.dst[0]};
            default: begin
                rd_mux = 32'h0;
                o_pslverr = i_psel && i_penable;
            end
        endcase
    end

    always_comb begin
        logic fire_a;
        logic fire_b;
        logic b_ok;
        logic deliver_a;
        logic deliver_b;
        logic ib_cyc;
        logic [31:0] ctl_w;
        s_d = s_q;
        fire_a = 1'b0;
        fire_b = 1'b0;
        b_ok = 1'b0;
        ib_cyc = i_cyc_ibus;
        ctl_w = s_q.ctrl;
        s_d.brk = 1'b0;

        // before-execution fetch breaks wait for the confirming signal
        deliver_a = hit_a && (i_cyc_data || i_fetch_exec) && i_brk_accept;
        deliver_b = hit_b && (i_cyc_data || i_fetch_exec) && i_brk_accept;

        b_ok = deliver_b;
        if (deliver_b && s_q.ctrl[`UBST_CTL_COUNT_EN]) begin
            b_ok = (s_q.exec_cnt == `UBST_EXEC_ONE);
        end

        if (s_q.ctrl[`UBST_CTL_CHAIN]) begin
            // a hit on both channels at once neither arms nor fires
            fire_a = 1'b0;
            unique case (s_q.seq)
                UBST_SEQ_IDLE: begin
                    if (deliver_a && !deliver_b) begin
                        s_d.seq = UBST_SEQ_ARMED;
                        s_d.ap_ib = ib_cyc;
                    end
                end
                UBST_SEQ_ARMED: begin
                    fire_b = b_ok && !deliver_a;
                end
            endcase
        end else begin
            s_d.seq = UBST_SEQ_IDLE;
            fire_a = deliver_a;
            fire_b = b_ok;
        end
        // count stays at zero until rewritten: no further counted break
        if (deliver_b && s_q.ctrl[`UBST_CTL_COUNT_EN] &&
            s_q.exec_cnt != 12'h0 &&
            (!s_q.ctrl[`UBST_CTL_CHAIN] || s_q.seq == UBST_SEQ_ARMED)) begin
            s_d.exec_cnt = s_q.exec_cnt - `UBST_EXEC_ONE;
        end

        s_d.brk = fire_a || fire_b;

        // apb writes to control; set wins over clear on match flags
        if (apb_wr && i_paddr == `UBST_OFF_CTRL) begin
            ctl_w = i_pwdata & `UBST_CTL_WMASK;
            // a one written to a flag sets it; only a zero clears it
            if (ctl_w[`UBST_CTL_TRACE_EN] &&
                !s_q.ctrl[`UBST_CTL_TRACE_EN]) begin
                s_d.src_v = 4'h0;
                s_d.dst_v = 4'h0;
            end
        end
        s_d.ctrl = ctl_w;
        if (fire_a || (fire_b && s_q.ctrl[`UBST_CTL_CHAIN])) begin
            if (s_q.ctrl[`UBST_CTL_CHAIN] ? s_q.ap_ib : ib_cyc) begin
                s_d.ctrl[`UBST_CTL_MFIA] = 1'b1;
            end else begin
                s_d.ctrl[`UBST_CTL_MFLA] = 1'b1;
            end
        end
        if (fire_b) begin
            if (ib_cyc) begin
                s_d.ctrl[`UBST_CTL_MFIB] = 1'b1;
            end else begin
                s_d.ctrl[`UBST_CTL_MFLB] = 1'b1;
            end
        end
        if (fire_b && s_q.ctrl[`UBST_CTL_CHAIN]) begin
            s_d.seq = UBST_SEQ_IDLE;
        end

        if (apb_wr) begin
            unique case (i_paddr)
                `UBST_OFF_ADDR_A: s_d.bar_a = i_pwdata;
                `UBST_OFF_AMASK_A: s_d.bam_a = i_pwdata;
                `UBST_OFF_CYC_A: s_d.bbr_a = i_pwdata[15:0] & `UBST_BC_MASK;
                `UBST_OFF_ADDR_B: s_d.bar_b = i_pwdata;
                `UBST_OFF_AMASK_B: s_d.bam_b = i_pwdata;
                `UBST_OFF_DATA_B: s_d.bdr_b = i_pwdata;
                `UBST_OFF_DMASK_B: s_d.bdm_b = i_pwdata;
                `UBST_OFF_CYC_B: s_d.bbr_b = i_pwdata[15:0] & `UBST_BC_MASK;
                `UBST_OFF_EXEC: s_d.exec_cnt = i_pwdata[11:0];
                // trace words and unmapped writes are dropped
                default: s_d.bar_a = s_d.bar_a;
            endcase
        end

        // read of source clears its flag; destination read advances
        if (apb_rd && i_paddr == `UBST_OFF_SRC) begin
            s_d.src_v[0] = 1'b0;
        end
        if (apb_rd && i_paddr == `UBST_OFF_DST) begin
            s_d.dst_v[0] = 1'b0;
            for (int i = 0; i < `UBST_DEPTH - 1; i++) begin
                s_d.src[i] = s_q.src[i + 1];
                s_d.dst[i] = s_q.dst[i + 1];
                s_d.src_v[i] = s_d.src_v[i + 1];
                s_d.dst_v[i] = s_d.dst_v[i + 1];
            end
            s_d.src_v[`UBST_DEPTH - 1] = 1'b0;
            s_d.dst_v[`UBST_DEPTH - 1] = 1'b0;
        end
        // a new branch pushes at the head; oldest entry falls off
        if (i_branch && s_q.ctrl[`UBST_CTL_TRACE_EN]) begin
            for (int i = `UBST_DEPTH - 1; i > 0; i--) begin
                s_d.src[i] = s_d.src[i - 1];
                s_d.dst[i] = s_d.dst[i - 1];
                s_d.src_v[i] = s_d.src_v[i - 1];
                s_d.dst_v[i] = s_d.dst_v[i - 1];
            end
            s_d.src[0] = i_branch_src[`UBST_ADDR_W - 1:0];
            s_d.dst[0] = i_branch_dst[`UBST_ADDR_W - 1:0];
            s_d.src_v[0] = 1'b1;
            s_d.dst_v[0] = 1'b1;
        end

        s_d.rdata = apb_rsetup ? rd_mux : s_q.rdata;
        s_d.bp_ib = ib_cyc;
        // a stalled cycle drops the pulse rather than stretching it
        if (!i_clk_en) begin
            s_d = s_q;
            s_d.brk = 1'b0;
        end
    end

    // trace addresses are left out of reset on purpose
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            // trace words hold through reset; only their valids clear
            s_q.bar_a <= 32'h0;
            s_q.bam_a <= 32'h0;
            s_q.bbr_a <= 16'h0;
            s_q.bar_b <= 32'h0;
            s_q.bam_b <= 32'h0;
            s_q.bdr_b <= 32'h0;
            s_q.bdm_b <= 32'h0;
            s_q.bbr_b <= 16'h0;
            s_q.ctrl <= 32'h0;
            s_q.exec_cnt <= 12'h0;
            s_q.seq <= UBST_SEQ_IDLE;
            s_q.src_v <= 4'h0;
            s_q.dst_v <= 4'h0;
            s_q.rdata <= 32'h0;
            s_q.brk <= 1'b0;
            s_q.ap_ib <= 1'b0;
            s_q.bp_ib <= 1'b0;
        end else begin
            s_q.bar_a <= s_d.bar_a;
            s_q.bam_a <= s_d.bam_a;
            s_q.bbr_a <= s_d.bbr_a;
            s_q.bar_b <= s_d.bar_b;
            s_q.bam_b <= s_d.bam_b;
            s_q.bdr_b <= s_d.bdr_b;
            s_q.bdm_b <= s_d.bdm_b;
            s_q.bbr_b <= s_d.bbr_b;
            s_q.ctrl <= s_d.ctrl;
            s_q.exec_cnt <= s_d.exec_cnt;
            s_q.seq <= s_d.seq;
            s_q.src_v <= s_d.src_v;
            s_q.dst_v <= s_d.dst_v;
            s_q.rdata <= s_d.rdata;
            s_q.brk <= s_d.brk;
            s_q.ap_ib <= s_d.ap_ib;
            s_q.bp_ib <= s_d.bp_ib;
            s_q.src <= s_d.src;
            s_q.dst <= s_d.dst;
        end
    end

    assign o_break_req = s_q.brk;
endmodule : ubst_core

// *** tb/ubst_core_sva.sv ***
// Purpose: port checks on the break and trace core
// Assumes: one clock domain, async active-low reset
// Notes: read data stands from the setup edge through the access phase
`include "ubst_consts.svh"
module ubst_core_sva (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_reset_n,
    // apb
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    // cpu side
    input wire logic i_cyc_valid,
    input wire logic i_cyc_data,
    input wire logic i_fetch_exec,
    input wire logic i_brk_accept,
    input wire logic o_break_req
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_reset_n);
    logic acc;
    logic rdac;
    assign acc = i_psel && i_penable;
    assign rdac = acc && !i_pwrite;

    chk_zero_wait: assert property (acc |-> o_pready)
        else $error("pready low in access phase");
    chk_unmapped_err: assert property (
        acc && i_paddr > `UBST_OFF_DST |-> o_pslverr)
        else $error("no error on unmapped access");
    chk_mapped_ok: assert property (acc && i_paddr <= `UBST_OFF_DST
        && i_paddr[1:0] == 2'h0 |-> !o_pslverr)
        else $error("error on mapped access");
    chk_unmapped_zero: assert property (
        rdac && i_paddr > `UBST_OFF_DST |-> o_prdata == 32'h0)
        else $error("unmapped read not zero");
    chk_count_rsvd: assert property (
        rdac && i_paddr == `UBST_OFF_EXEC |-> o_prdata[31:12] == 20'h0)
        else $error("count upper bits not zero");
    chk_src_rsvd: assert property (
        rdac && i_paddr == `UBST_OFF_SRC |-> o_prdata[30:28] == 3'h0)
        else $error("source reserved bits not zero");
    chk_dst_rsvd: assert property (
        rdac && i_paddr == `UBST_OFF_DST |-> o_prdata[30:28] == 3'h0)
        else $error("destination reserved bits not zero");
    chk_break_cause: assert property (
        o_break_req |-> $past(i_cyc_valid && i_brk_accept))
        else $error("break without accepted bus cycle");
    chk_fetch_exec: assert property (
        o_break_req && !$past(i_cyc_data) |-> $past(i_fetch_exec))
        else $error("fetch break on unexecuted fetch");
endmodule : ubst_core_sva

bind ubst_core ubst_core_sva u_sva (.i_clock, .i_reset_n, .i_psel,
    .i_penable, .i_pwrite, .i_paddr, .o_prdata, .o_pready, .o_pslverr,
    .i_cyc_valid, .i_cyc_data, .i_fetch_exec, .i_brk_accept,
    .o_break_req);

// *** tb/ubst_cpu_model.sv ***
// Purpose: cpu core and bus model facing the break core
// Assumes: one bus cycle per call, driven after a rising edge
// Notes: released address and data lines show inverted values; valid drops, other cycle lines keep the old cycle
module ubst_cpu_model (
    input wire logic i_clock,
    // bus cycle
    output logic o_cyc_valid,
    output logic o_cyc_ibus,
    output logic o_cyc_data,
    output logic o_cyc_write,
    output logic [1:0] o_cyc_size,
    output logic [31:0] o_cyc_addr,
    output logic [31:0] o_cyc_wdata,
    output logic o_fetch_exec,
    output logic o_brk_accept,
    // branch
    output logic o_branch,
    output logic [31:0] o_branch_src,
    output logic [31:0] o_branch_dst
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {o_cyc_valid, o_cyc_ibus, o_cyc_data, o_cyc_write} = 4'h0;
        {o_cyc_size, o_cyc_addr, o_cyc_wdata} = 66'h0;
        {o_fetch_exec, o_brk_accept, o_branch} = 3'h0;
        {o_branch_src, o_branch_dst} = 64'h0;
    end
    // k: ibus, data, write, executes, accepts
    task automatic run(input logic [4:0] k, input logic [1:0] sz,
                       input logic [31:0] a, input logic [31:0] d);
        @(posedge i_clock);
        o_cyc_valid <= 1'b1;
        {o_cyc_ibus, o_cyc_data, o_cyc_write} <= k[4:2];
        o_fetch_exec <= k[1];
        o_brk_accept <= k[0];
        o_cyc_size <= sz;
        o_cyc_addr <= a;
        o_cyc_wdata <= d;
        @(posedge i_clock);
        o_cyc_valid <= 1'b0;
        o_cyc_addr <= ~a;
        o_cyc_wdata <= ~d;
    endtask : run
    task automatic branch(input logic [31:0] s, input logic [31:0] t);
        @(posedge i_clock);
        o_branch <= 1'b1;
        o_branch_src <= s;
        o_branch_dst <= t;
        @(posedge i_clock);
        o_branch <= 1'b0;
        o_branch_src <= ~s;
        o_branch_dst <= ~t;
    endtask : branch
endmodule : ubst_cpu_model

// *** tb/tb_top.sv ***
// Purpose: directed apb and bus-cycle test of the break core
// Assumes: zero-wait apb slave, cpu model drives bus cycles
// Notes: clock enable dropped once to check the freeze
`include "ubst_consts.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] LF = 5'h03;
    localparam logic [4:0] IFE = 5'h13;
    localparam logic [4:0] DW = 5'h0f;
    logic clock, reset_n, psel, penable, pwrite, pready, pslverr, brk;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic cv, cib, cd, cw, fx, acc, br, ce;
    logic [1:0] csz;
    logic [31:0] ca, cwd, bs, bd;
    logic [31:0] off0 [3] = '{32'h14, 32'h44, 32'h50};
    logic [1:0] dsz [6] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h2, 2'h3};
    logic [31:0] dad [6] = '{32'h1000, 32'h1002, 32'h1003,
                             32'h1002, 32'h1000, 32'h1004};
    logic dex [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    int n_errors = 0;
    int n_tests = 0;

    ubst_core uut (.i_clock(clock), .i_reset_n(reset_n),
        .i_clk_en(ce), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_cyc_valid(cv), .i_cyc_ibus(cib), .i_cyc_data(cd),
        .i_cyc_write(cw), .i_cyc_size(csz), .i_cyc_addr(ca),
        .i_cyc_wdata(cwd), .i_fetch_exec(fx), .i_brk_accept(acc),
        .i_branch(br), .i_branch_src(bs), .i_branch_dst(bd),
        .o_break_req(brk));
    ubst_cpu_model cpu (.i_clock(clock), .o_cyc_valid(cv),
        .o_cyc_ibus(cib), .o_cyc_data(cd), .o_cyc_write(cw),
        .o_cyc_size(csz), .o_cyc_addr(ca), .o_cyc_wdata(cwd),
        .o_fetch_exec(fx), .o_brk_accept(acc), .o_branch(br),
        .o_branch_src(bs), .o_branch_dst(bd));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic end_sim;
        if (n_errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        // read data stands through the access phase; take it at its edge
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic w32(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : w32
    task automatic rchk(input string nm, input logic [11:0] a,
                        input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(nm, rd, exp);
    endtask : rchk
    task automatic setup(input logic [31:0] ba, input logic [31:0] bb,
        input logic [7:0] sa, input logic [7:0] sb, input logic [31:0] c);
        w32(`UBST_OFF_ADDR_A, ba);
        w32(`UBST_OFF_ADDR_B, bb);
        w32(`UBST_OFF_CTRL, c);
        w32(`UBST_OFF_CYC_A, {24'h0, sa});
        w32(`UBST_OFF_CYC_B, {24'h0, sb});
    endtask : setup
    task automatic hit(input logic [4:0] k, input logic [1:0] sz,
        input logic [31:0] a, input logic [31:0] d, input logic e);
        cpu.run(k, sz, a, d);
        #1;
        chk("break", {31'h0, brk}, {31'h0, e});
    endtask : hit

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = 47'h0;
        ce = 1'b1;
        reset_n = 1'b0;
        repeat (4) @(posedge clock);
        reset_n <= 1'b1;
        rchk("exec_count", `UBST_OFF_EXEC, 32'h0);
        rchk("control", `UBST_OFF_CTRL, 32'h0);
        w32(`UBST_OFF_EXEC, 32'hffffffff);
        rchk("exec_count", `UBST_OFF_EXEC, 32'h00000fff);
        rchk("unmapped", 12'h040, 32'h0);
        setup(32'h404, 32'h0, 8'h54, 8'h00, 32'h0);
        hit(LF, 2'h0, 32'h404, 32'h0, 1'b1);
        xfer(1'b0, `UBST_OFF_CTRL, 32'h0);
        chk("lflag_a", {31'h0, rd[15]}, 32'h1);
        hit(LF, 2'h0, 32'h408, 32'h0, 1'b0);
        hit(5'h01, 2'h0, 32'h404, 32'h0, 1'b0);
        hit(5'h02, 2'h0, 32'h404, 32'h0, 1'b0);
        hit(IFE, 2'h0, 32'h404, 32'h0, 1'b0);
        foreach (off0[i]) begin
            w32(`UBST_OFF_CYC_A, off0[i]);
            hit(LF, 2'h0, 32'h404, 32'h0, 1'b0);
        end
        // mask bit 0 so only the lsb rule can block the hit
        w32(`UBST_OFF_AMASK_A, 32'h1);
        setup(32'h405, 32'h0, 8'h54, 8'h00, 32'h0);
        hit(LF, 2'h0, 32'h404, 32'h0, 1'b0);
        w32(`UBST_OFF_AMASK_A, 32'h0);
        setup(32'h404, 32'h0, 8'h94, 8'h00, 32'h0);
        hit(IFE, 2'h0, 32'h404, 32'h0, 1'b1);
        xfer(1'b0, `UBST_OFF_CTRL, 32'h0);
        chk("iflag_a", {31'h0, rd[13]}, 32'h1);
        w32(`UBST_OFF_CTRL, 32'h0);
        rchk("control", `UBST_OFF_CTRL, 32'h0);
        setup(32'h1003, 32'h0, 8'h6f, 8'h00, 32'h0);
        foreach (dsz[i]) begin
            w32(`UBST_OFF_CYC_A, {24'h0, 6'h1b, dsz[i]});
            hit(DW, dsz[i], dad[i], 32'h0, dex[i]);
        end
        w32(`UBST_OFF_DATA_B, 32'h00005a5a);
        w32(`UBST_OFF_DMASK_B, 32'h0);
        setup(32'h0, 32'h2001, 8'h00, 8'h69, 32'h80);
        hit(DW, `UBST_SZ_BYTE, 32'h2001, 32'hffff5a5a, 1'b1);
        hit(DW, `UBST_SZ_BYTE, 32'h2001, 32'h00005a5b, 1'b0);
        setup(32'h0, 32'h2000, 8'h00, 8'h54, 32'h80);
        hit(LF, 2'h0, 32'h2000, 32'h0, 1'b1);
        w32(`UBST_OFF_EXEC, 32'h3);
        w32(`UBST_OFF_CTRL, 32'h1);
        hit(LF, 2'h0, 32'h2000, 32'h0, 1'b0);
        rchk("exec_count", `UBST_OFF_EXEC, 32'h2);
        hit(LF, 2'h0, 32'h2000, 32'h0, 1'b0);
        rchk("exec_count", `UBST_OFF_EXEC, 32'h1);
        hit(LF, 2'h0, 32'h2000, 32'h0, 1'b1);
        w32(`UBST_OFF_CTRL, 32'h0);
        setup(32'h404, 32'h404, 8'h54, 8'h54, 32'h8);
        hit(LF, 2'h0, 32'h404, 32'h0, 1'b0);
        w32(`UBST_OFF_CTRL, 32'h0);
        setup(32'h404, 32'h2000, 8'h54, 8'h54, 32'h8);
        hit(LF, 2'h0, 32'h2000, 32'h0, 1'b0);
        hit(LF, 2'h0, 32'h404, 32'h0, 1'b0);
        hit(LF, 2'h0, 32'h2000, 32'h0, 1'b1);
        w32(`UBST_OFF_CTRL, 32'h0);
        hit(LF, 2'h0, 32'h2000, 32'h0, 1'b1);
        @(posedge clock);
        ce <= 1'b0;
        hit(LF, 2'h0, 32'h2000, 32'h0, 1'b0);
        @(posedge clock);
        ce <= 1'b1;
        hit(LF, 2'h0, 32'h2000, 32'h0, 1'b1);
        w32(`UBST_OFF_CTRL, 32'h800);
        cpu.branch(32'hf0000010, 32'h20);
        cpu.branch(32'h30, 32'h40);
        rchk("source", `UBST_OFF_SRC, 32'h80000030);
        rchk("source", `UBST_OFF_SRC, 32'h00000030);
        rchk("destination", `UBST_OFF_DST, 32'h80000040);
        rchk("source", `UBST_OFF_SRC, 32'h80000010);
        rchk("destination", `UBST_OFF_DST, 32'h80000020);
        cpu.branch(32'h50, 32'h60);
        w32(`UBST_OFF_CTRL, 32'h0);
        w32(`UBST_OFF_CTRL, 32'h800);
        xfer(1'b0, `UBST_OFF_SRC, 32'h0);
        chk("source_valid", {31'h0, rd[31]}, 32'h0);
        xfer(1'b0, `UBST_OFF_DST, 32'h0);
        chk("dest_valid", {31'h0, rd[31]}, 32'h0);
        end_sim();
    end

    // whole sequence needs about three hundred cycles
    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        end_sim();
    end
endmodule : tb_top
